// ### src/ptr_pkg.sv
package ptr_pkg;
	// control mode digit value that enables the pulse-train position path
	localparam logic [3:0] PTR_MODE_PULSE = 4'h1;
	// pulse form digit values
	localparam logic [3:0] PTR_FORM_STEP_DIR = 4'h0;
	localparam logic [3:0] PTR_FORM_FWD_REV = 4'h1;
	localparam logic [3:0] PTR_FORM_QUAD_X1 = 4'h2;
	localparam logic [3:0] PTR_FORM_QUAD_X2 = 4'h3;
	localparam logic [3:0] PTR_FORM_QUAD_X4 = 4'h4;
	// clear mode digit values
	localparam logic [1:0] PTR_CLR_SOFF = 2'h0;
	localparam logic [1:0] PTR_CLR_NEVER = 2'h1;
	localparam logic [1:0] PTR_CLR_SOFF_OT = 2'h2;
	// inversion digit bits
	localparam int PTR_INV_DIR_BIT = 0;
	localparam int PTR_INV_STEP_BIT = 1;
	// filter digit values and accepted rates in kHz
	localparam logic [1:0] PTR_FILT_FAST = 2'h0;
	localparam logic [1:0] PTR_FILT_MID = 2'h1;
	localparam logic [1:0] PTR_FILT_SLOW = 2'h2;
	localparam int PTR_CLK_KHZ = 10000;
	localparam int PTR_RATE_FAST_KHZ = 4000;
	localparam int PTR_RATE_MID_KHZ = 650;
	localparam int PTR_RATE_SLOW_KHZ = 150;
	// a level must stand for half a period of the highest accepted rate (round down, at least one)
	localparam int PTR_FILT_FAST_CYC = (PTR_CLK_KHZ / (2 * PTR_RATE_FAST_KHZ)) < 1 ? 1 :
		PTR_CLK_KHZ / (2 * PTR_RATE_FAST_KHZ);
	localparam int PTR_FILT_MID_CYC = PTR_CLK_KHZ / (2 * PTR_RATE_MID_KHZ);
	localparam int PTR_FILT_SLOW_CYC = PTR_CLK_KHZ / (2 * PTR_RATE_SLOW_KHZ);
	localparam int PTR_FILT_W = 6;
	// host limits in kpps
	localparam int PTR_HOST_MAX_KPPS = 500;
	localparam int PTR_HOST_X2_KPPS = 400;
	localparam int PTR_HOST_OC_KPPS = 200;
	// host half period at 500kpps: 1000 ns, 10 cycles of 100 ns
	localparam int PTR_CLK_NS = 100;
	localparam int PTR_HALF_NS = 1000000 / (2 * PTR_HOST_MAX_KPPS);
	localparam int PTR_HALF_CYC = PTR_HALF_NS / PTR_CLK_NS;
	// gear limits
	localparam int PTR_GEAR_W = 16;
	localparam logic [15:0] PTR_GEAR_DEFAULT = 16'h0001;
	localparam int PTR_ERR_W = 32;
endpackage : ptr_pkg

// ### src/ptr_link_if.sv
`timescale 1ns/10ps
// pulse-train link between host controller and drive
interface ptr_link_if;
	logic step; // pulse line, also phase A or forward line
	logic dir; // sign line, also phase B or reverse line
	logic error_counter_clear_n;
	modport host_end (output step, output dir, output error_counter_clear_n);
	modport drive_end (input step, input dir, input error_counter_clear_n);
endinterface : ptr_link_if

// ### src/ptr_drive.sv
`timescale 1ns/10ps
//Operation
//- path runs only in pulse-train position mode
//- filter digit sets accepted pulse rate
//- step counts; direction high forward, low reverse
//- forward/reverse lines count up/down separately
//- quadrature: B leading A is forward
//- quadrature digits 2,3,4 give x1,x2,x4
//- host stays within 500kpps, 200kpps open-collector
//- host quadrature limits 500/400/200kpps by multiplier
//- inversion digit flips step and/or direction
//- clear input low holds counter zero, loop off
//- clear mode: servo-off, never, servo-off/overtravel; here the third clears nothing while zero_clamp is high
//- gear numerator/denominator latched at restart
//- configurer keeps gear ratio within 0.01..100
//- configurer picks stronger filter on noise
module ptr_drive
	import ptr_pkg::*;
#(
	parameter int ERR_W = PTR_ERR_W
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	ptr_link_if.drive_end link,
	input wire logic [3:0] control_mode_param,
	input wire logic [3:0] pulse_form_param,
	input wire logic [1:0] pulse_invert_param,
	input wire logic [1:0] clear_mode_param,
	input wire logic [1:0] input_filter_param,
	input wire logic [15:0] gear_numerator,
	input wire logic [15:0] gear_denominator,
	input wire logic servo_on,
	input wire logic overtravel,
	input wire logic zero_clamp,
	input wire logic fb_pulse,
	input wire logic fb_dir,
	output logic signed [ERR_W-1:0] position_error,
	output logic position_loop_enable,
	output logic ref_pulse
);
	logic [1:0] step_sync_r, dir_sync_r, clr_sync_r;
	logic [1:0] filt_r; // filtered step (0) and direction (1)
	logic [1:0] filt_d_r;
	logic [PTR_FILT_W-1:0] fcnt_r [2];
	logic [PTR_FILT_W-1:0] flimit;
	logic [15:0] num_r, den_r;
	logic started_r;
	logic signed [2:0] ref_cnt;
	logic path_on;
	logic clr_mode_hit;
	logic a_rise, a_fall, b_rise, b_fall;

	// two flops on every pin before anything looks at it
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			step_sync_r <= 2'h0;
			dir_sync_r <= 2'h0;
			clr_sync_r <= 2'h3;
		end
		else
		begin
			step_sync_r <= {step_sync_r[0], link.step};
			dir_sync_r <= {dir_sync_r[0], link.dir};
			clr_sync_r <= {clr_sync_r[0], link.error_counter_clear_n};
		end
	end

	// glitch window chosen by filter digit; unknown digits fall back to slowest, the safe side
	always_comb
	begin
		unique case (input_filter_param)
			PTR_FILT_FAST: flimit = PTR_FILT_W'(PTR_FILT_FAST_CYC);
			PTR_FILT_MID: flimit = PTR_FILT_W'(PTR_FILT_MID_CYC);
			default: flimit = PTR_FILT_W'(PTR_FILT_SLOW_CYC);
		endcase
	end

	// a new level is accepted only once stable for the window; shorter glitches die here
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_filt
			logic raw;
			assign raw = (i == 0) ? (step_sync_r[1] ^ pulse_invert_param[PTR_INV_STEP_BIT]) :
				(dir_sync_r[1] ^ pulse_invert_param[PTR_INV_DIR_BIT]);
			always_ff @(posedge sys_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					fcnt_r[i] <= '0;
					filt_r[i] <= 1'b0;
				end
				else if (raw == filt_r[i])
					fcnt_r[i] <= '0;
				else if (fcnt_r[i] + 1'b1 >= flimit)
				begin
					fcnt_r[i] <= '0;
					filt_r[i] <= raw;
				end
				else
					fcnt_r[i] <= fcnt_r[i] + 1'b1;
			end
		end
	endgenerate

	// previous filtered levels for edge detection
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			filt_d_r <= 2'h0;
		else
			filt_d_r <= filt_r;
	end

	assign a_rise = filt_r[0] & ~filt_d_r[0];
	assign a_fall = ~filt_r[0] & filt_d_r[0];
	assign b_rise = filt_r[1] & ~filt_d_r[1];
	assign b_fall = ~filt_r[1] & filt_d_r[1];
	assign path_on = (control_mode_param == PTR_MODE_PULSE);

	// decode the selected pulse form into a signed count of -1, 0 or +1
	always_comb
	begin
		ref_cnt = 3'sd0;
		if (path_on)
		begin
			unique case (pulse_form_param)
				PTR_FORM_STEP_DIR:
					if (a_rise)
						ref_cnt = filt_r[1] ? 3'sd1 : -3'sd1;
				PTR_FORM_FWD_REV:
					ref_cnt = (a_rise ? 3'sd1 : 3'sd0) - (b_rise ? 3'sd1 : 3'sd0);
				PTR_FORM_QUAD_X1:
					if (a_rise)
						ref_cnt = filt_r[1] ? 3'sd1 : -3'sd1;
				PTR_FORM_QUAD_X2:
					if (a_rise | a_fall)
						ref_cnt = (filt_r[0] ^ filt_r[1]) ? -3'sd1 : 3'sd1;
				PTR_FORM_QUAD_X4:
					if (a_rise | a_fall)
						ref_cnt = (filt_r[0] ^ filt_r[1]) ? -3'sd1 : 3'sd1;
					else if (b_rise | b_fall)
						ref_cnt = (filt_r[0] ^ filt_r[1]) ? 3'sd1 : -3'sd1;
				default: ref_cnt = 3'sd0;
			endcase
		end
	end

	// gear values are caught once after reset release, so later changes need a restart
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			started_r <= 1'b0;
			num_r <= PTR_GEAR_DEFAULT;
			den_r <= PTR_GEAR_DEFAULT;
		end
		else if (!started_r)
		begin
			started_r <= 1'b1;
			num_r <= (gear_numerator == 16'h0) ? PTR_GEAR_DEFAULT : gear_numerator;
			den_r <= (gear_denominator == 16'h0) ? PTR_GEAR_DEFAULT : gear_denominator;
		end
	end

	// fractional scaler: add numerator per reference, emit whole units per denominator;
	// output is at most one whole unit per cycle; any excess waits in the remainder for later cycles
	logic signed [ERR_W-1:0] scaled;
	// exact scaling by multiply then divide would need a divider; use num*count here
	// and carry the division in the remainder below
	logic signed [ERR_W+PTR_GEAR_W-1:0] frac_r, frac_nxt;
	logic signed [ERR_W-1:0] whole;
	always_comb
	begin
		frac_nxt = frac_r + (ERR_W+PTR_GEAR_W)'(ref_cnt) * $signed({1'b0, num_r});
		whole = '0;
		if (frac_nxt >= $signed({1'b0, den_r}))
			whole = ERR_W'(1);
		else if (frac_nxt <= -$signed({1'b0, den_r}))
			whole = -ERR_W'(1);
		scaled = whole;
	end

	// remainder keeps the untaken part so no fraction of a reference is lost
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			frac_r <= '0;
		else if (!clr_sync_r[1])
			frac_r <= '0;
		else
			frac_r <= frac_nxt - (ERR_W+PTR_GEAR_W)'(whole) * $signed({1'b0, den_r});
	end

	// clear events chosen by the clear mode
	always_comb
	begin
		unique case (clear_mode_param)
			PTR_CLR_SOFF: clr_mode_hit = ~servo_on;
			PTR_CLR_NEVER: clr_mode_hit = 1'b0;
			PTR_CLR_SOFF_OT: clr_mode_hit = (~servo_on | overtravel) & ~zero_clamp;
			default: clr_mode_hit = 1'b0;
		endcase
	end

	// error counter: clear wins over counting
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			position_error <= '0;
			position_loop_enable <= 1'b0;
			ref_pulse <= 1'b0;
		end
		else
		begin
			ref_pulse <= (ref_cnt != 3'sd0);
			position_loop_enable <= clr_sync_r[1] & path_on;
			if (!clr_sync_r[1] || clr_mode_hit)
				position_error <= '0;
			else
				position_error <= position_error + scaled -
					(fb_pulse ? (fb_dir ? ERR_W'(1) : -ERR_W'(1)) : ERR_W'(0));
		end
	end
endmodule : ptr_drive

// ### src/ptr_host.sv
`timescale 1ns/10ps
// host end: turns move requests into the chosen pulse form at no more than 500kpps
module ptr_host
	import ptr_pkg::*;
#(
	parameter int HALF_CYC = PTR_HALF_CYC
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	ptr_link_if.host_end link,
	input wire logic [3:0] pulse_form_param,
	input wire logic move_req,
	input wire logic move_fwd,
	input wire logic clear_req,
	output logic move_ready
);
	typedef enum logic [1:0] {PTR_H_IDLE = 2'b00, PTR_H_LEAD = 2'b01, PTR_H_HOLD = 2'b10} ptr_hstate_t;
	ptr_hstate_t state_r;
	logic [7:0] cnt_r;
	logic fwd_r;
	logic [1:0] phase_r; // quadrature phase, gray sequence on {b,a}

	// each request is one reference: a full pulse, or one quadrature step; the half
	// period spacing keeps the host within its rate limit in every form
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= PTR_H_IDLE;
			cnt_r <= 8'h0;
			fwd_r <= 1'b1;
			phase_r <= 2'h0;
			link.step <= 1'b0;
			link.dir <= 1'b0;
			move_ready <= 1'b1;
		end
		else
		begin
			unique case (state_r)
				PTR_H_IDLE:
					if (move_req)
					begin
						fwd_r <= move_fwd;
						move_ready <= 1'b0;
						cnt_r <= 8'(HALF_CYC);
						state_r <= PTR_H_LEAD;
						if (pulse_form_param == PTR_FORM_STEP_DIR)
							link.dir <= move_fwd;
						else if (pulse_form_param == PTR_FORM_FWD_REV)
							link.dir <= 1'b0; // a reverse line left high by another form drops well before the pulse
						else if (pulse_form_param >= PTR_FORM_QUAD_X1)
						begin
							// b leads a when moving forward: 00,10,11,01
							phase_r <= move_fwd ? phase_r + 2'h1 : phase_r - 2'h1;
							link.dir <= (move_fwd ? phase_r + 2'h1 : phase_r - 2'h1) inside {2'h1, 2'h2};
							link.step <= (move_fwd ? phase_r + 2'h1 : phase_r - 2'h1) inside {2'h2, 2'h3};
						end
					end
				PTR_H_LEAD:
					if (cnt_r != 8'h0)
						cnt_r <= cnt_r - 8'h1;
					else
					begin
						cnt_r <= 8'(HALF_CYC);
						state_r <= PTR_H_HOLD;
						if (pulse_form_param == PTR_FORM_STEP_DIR)
							link.step <= 1'b1;
						else if (pulse_form_param == PTR_FORM_FWD_REV)
						begin
							link.step <= fwd_r;
							link.dir <= ~fwd_r;
						end
					end
				PTR_H_HOLD:
					if (cnt_r != 8'h0)
						cnt_r <= cnt_r - 8'h1;
					else
					begin
						if (pulse_form_param < PTR_FORM_QUAD_X1)
						begin
							link.step <= 1'b0;
							if (pulse_form_param == PTR_FORM_FWD_REV)
								link.dir <= 1'b0;
						end
						move_ready <= 1'b1;
						state_r <= PTR_H_IDLE;
					end
				default: state_r <= PTR_H_IDLE;
			endcase
		end
	end

	// clear line is driven low while the user asks for it
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			link.error_counter_clear_n <= 1'b1;
		else
			link.error_counter_clear_n <= ~clear_req;
	end
endmodule : ptr_host

// ### testbench/ptr_link_chk.sv
`timescale 1ns/10ps
// watches the link wires and the error counter they feed
module ptr_link_chk #(
	parameter int ERR_W = 32
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic step,
	input wire logic dir,
	input wire logic error_counter_clear_n,
	input wire logic signed [ERR_W-1:0] position_error,
	input wire logic position_loop_enable
);
	logic [7:0] clr_low_r;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// run length of a low clear, saturating so a long clear never wraps
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			clr_low_r <= 8'h00;
		else if (error_counter_clear_n)
			clr_low_r <= 8'h00;
		else if (clr_low_r != 8'hff)
			clr_low_r <= clr_low_r + 8'h01;
	end
	// counter at zero with the loop off
	sequence err_held;
		position_error == 0 && !position_loop_enable;
	endsequence
	sequence clr_start;
		$fell(error_counter_clear_n);
	endsequence
	a_step_high_min: assert property ($rose(step) |-> step [*8])
		else $error("step high too short");
	a_step_low_min: assert property ($fell(step) |-> !step [*8])
		else $error("step gap too short");
	a_dir_setup: assert property ($rose(step) |-> dir == $past(dir, 8))
		else $error("dir moved close to step");
	a_idle_reset: assert property ($rose(rst_n) |-> !step && !dir && error_counter_clear_n ##0 err_held)
		else $error("not idle after reset");
	// 40 cycles covers the two sync flops and the output flop; the clear line has no filter
	a_clear_err: assert property (clr_start |-> ##[1:40] position_error == 0)
		else $error("clear did not zero counter");
	a_clear_loop: assert property (clr_start |-> ##[1:40] !position_loop_enable)
		else $error("clear did not stop loop");
	a_clear_hold: assert property (clr_low_r >= 8'h28 |-> err_held)
		else $error("counter moved under clear");
	a_clear_rel: assert property ($rose(error_counter_clear_n) |-> err_held)
		else $error("counter moved before release");
endmodule : ptr_link_chk

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %0d got %0d", nm, e, g); end end
// host and drive face each other; the bench plays the motion program
module tb_top;
	import ptr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] control_mode_param = 4'h1;
	logic [3:0] pulse_form_param = 4'h0;
	logic [1:0] pulse_invert_param = 2'h0;
	logic [1:0] clear_mode_param = 2'h1;
	logic [1:0] input_filter_param = 2'h0;
	logic [15:0] gear_numerator = 16'h0001;
	logic [15:0] gear_denominator = 16'h0001;
	logic servo_on = 1'b1, overtravel = 1'b0, zero_clamp = 1'b0, fb_pulse = 1'b0, fb_dir = 1'b0;
	logic move_req = 1'b0, move_fwd = 1'b0, clear_req = 1'b0, move_ready, position_loop_enable, ref_pulse;
	logic signed [PTR_ERR_W-1:0] position_error;
	int n_fail = 0;
	int n_compared = 0;
	int n_ref = 0;
	int ref_base;
	int fm[4] = '{1, 2, 3, 4};
	int fe[4] = '{4, 1, 2, 4};
	int cm[5] = '{0, 0, 1, 2, 2};
	int so[5] = '{0, 1, 0, 1, 0};
	int ov[5] = '{0, 1, 1, 1, 1};
	int zc[5] = '{0, 0, 0, 0, 1};
	int ex[5] = '{0, 2, 2, 0, 2};
	ptr_link_if link();
	ptr_host ptr_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .pulse_form_param(pulse_form_param),
		.move_req(move_req), .move_fwd(move_fwd), .clear_req(clear_req), .move_ready(move_ready));
	ptr_drive ptr_drive_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .control_mode_param(control_mode_param),
		.pulse_form_param(pulse_form_param), .pulse_invert_param(pulse_invert_param),
		.clear_mode_param(clear_mode_param), .input_filter_param(input_filter_param),
		.gear_numerator(gear_numerator), .gear_denominator(gear_denominator), .servo_on(servo_on),
		.overtravel(overtravel), .zero_clamp(zero_clamp), .fb_pulse(fb_pulse), .fb_dir(fb_dir),
		.position_error(position_error), .position_loop_enable(position_loop_enable), .ref_pulse(ref_pulse));
	ptr_link_chk #(.ERR_W(PTR_ERR_W)) ptr_link_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .step(link.step), .dir(link.dir),
		.error_counter_clear_n(link.error_counter_clear_n), .position_error(position_error),
		.position_loop_enable(position_loop_enable));
	always #50 sys_clk = ~sys_clk;
	// decoded references before the gear, so decoding and gearing are told apart
	always @(posedge sys_clk)
		if (ref_pulse === 1'b1)
			n_ref <= n_ref + 1;
	// inputs change 1 ns after the edge so no race with the design flops
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	// one request per idle host, bounded wait
	task automatic mv(input logic f, input int n);
		int k;
		repeat (n)
		begin
			for (k = 0; k < 100 && move_ready !== 1'b1; k++)
				tick(1);
			if (k == 100)
			begin
				n_fail++;
				summarize();
			end
			move_fwd = f;
			move_req = 1'b1;
			tick(1);
			move_req = 1'b0;
			tick(2);
			`CHK("move_ready", 1'b0, move_ready)
		end
	endtask : mv
	// held past the 40-cycle mark so the checker sees the counter held under clear
	task automatic clr();
		clear_req = 1'b1;
		tick(45);
		clear_req = 1'b0;
		tick(45);
	endtask : clr
	task automatic ck(input int e);
		tick(80);
		`CHK("position_error", e, position_error)
	endtask : ck
	// main sequence
	initial
	begin
		tick(2);
		rst_n = 1'b1;
		tick(2);
		mv(1'b1, 3);
		mv(1'b0, 1);
		ck(2);
		`CHK("loop_enable", 1'b1, position_loop_enable)
		clr();
		for (int i = 0; i < 4; i++)
		begin
			pulse_invert_param = 2'(i);
			tick(40);
			clr();
			mv(1'b1, 1);
			ck((i % 2) ? -1 : 1);
		end
		pulse_invert_param = 2'h0;
		for (int i = 0; i < 4; i++)
		begin
			pulse_form_param = 4'(fm[i]);
			tick(40);
			clr();
			mv(1'b1, 4);
			ck(fe[i]);
			clr();
			mv(1'b0, 4);
			ck(-fe[i]);
		end
		pulse_form_param = 4'h0;
		for (int i = 0; i < 3; i++)
		begin
			input_filter_param = 2'(i);
			tick(40);
			clr();
			mv(1'b1, 2);
			ck(i == 2 ? 0 : 2);
		end
		input_filter_param = 2'h0;
		control_mode_param = 4'h0;
		clr();
		ref_base = n_ref;
		mv(1'b1, 2);
		ck(0);
		`CHK("ref_pulse", 0, n_ref - ref_base)
		control_mode_param = 4'h1;
		tick(40);
		clr();
		fb_dir = 1'b1;
		fb_pulse = 1'b1;
		tick(3);
		fb_pulse = 1'b0;
		ck(-3);
		for (int i = 0; i < 5; i++)
		begin
			clear_mode_param = 2'(cm[i]);
			clr();
			mv(1'b1, 2);
			servo_on = 1'(so[i]);
			overtravel = 1'(ov[i]);
			zero_clamp = 1'(zc[i]);
			ck(ex[i]);
			servo_on = 1'b1;
			overtravel = 1'b0;
			zero_clamp = 1'b0;
		end
		// gear is taken only at restart, so a second reset is needed
		rst_n = 1'b0;
		gear_numerator = 16'h0003;
		gear_denominator = 16'h0002;
		clear_mode_param = 2'h1;
		tick(2);
		rst_n = 1'b1;
		tick(2);
		`CHK("position_error", 0, position_error)
		ref_base = n_ref;
		mv(1'b1, 4);
		ck(6);
		`CHK("ref_pulse", 4, n_ref - ref_base)
		gear_numerator = 16'h0001;
		gear_denominator = 16'h0001;
		mv(1'b1, 2);
		ck(9);
		summarize();
	end
endmodule : tb_top
